// ---- hdl/uwd_defines.vh ----
`ifndef UWD_DEFINES_VH
`define UWD_DEFINES_VH

// ----------------------------------------------------------------
// own wishbone registers (byte addresses)
// ----------------------------------------------------------------
`define UWD_WB_CTRL 8'h00
`define UWD_WB_GPIO 8'h04
`define UWD_WB_STAT 8'h08
`define UWD_WB_WSRC 8'h0c

// ctrl fields
`define UWD_CTRL_GO 0
`define UWD_CTRL_CMD_LSB 1
`define UWD_CTRL_SEL_LSB 4
`define UWD_CTRL_EXACT 6
`define UWD_CTRL_BCAST 7
`define UWD_CTRL_CTX_LSB 8
`define UWD_CTRL_RESET 32'h0000_0020

// gpio register fields
`define UWD_GPIO_POL_LSB 8
`define UWD_GPIO_CFGB 16

// commands
`define UWD_CMD_NONE 3'h0
`define UWD_CMD_DETACH 3'h1
`define UWD_CMD_GPIO 3'h2
`define UWD_CMD_LAN 3'h3
`define UWD_CMD_CHECK 3'h4
`define UWD_CMD_CLEAR 3'h5

// ----------------------------------------------------------------
// device register map (byte addresses on the device port)
// ----------------------------------------------------------------
`define UWD_DEV_INTERRUPT_STATUS_REGISTER 12'h00c
`define UWD_DEV_HARDWARE_CONFIG_REGISTER 12'h010
`define UWD_DEV_PMT 12'h014
`define UWD_DEV_CFG_A 12'h01c
`define UWD_DEV_CFG_B 12'h018
`define UWD_DEV_GPIO_WAKE 12'h020
`define UWD_DEV_MAC_CR 12'h100
`define UWD_DEV_WAKE_CONTROL_STATUS_1 12'h110
`define UWD_DEV_WAKE_SOURCE_REGISTER 12'h150

// device field positions
`define UWD_INT_PHY 26
`define UWD_HW_DETACH_EN 16
`define UWD_HW_DETACH_RET 17
`define UWD_PMT_SEL_LSB 29
`define UWD_PMT_LAN_WAKE 3
`define UWD_PMT_PHY_WAKE 4
`define UWD_PMT_WAKE_STATUS_BITS_LSB 6
`define UWD_CFG_PIN_EN_LSB 24
`define UWD_MAC_RX_EN 0
`define UWD_MAC_TX_EN 1
`define UWD_WU_BCAST 5
`define UWD_WU_EXACT 9

// suspend select codes
`define UWD_SEL_SLEEP_A 2'b00
`define UWD_SEL_DEEPEST 2'b10
`define UWD_SEL_ACTIVE 2'b11

// power-state contexts for the wake check
`define UWD_CTX_SLEEP_A 3'h0
`define UWD_CTX_DEEPEST 3'h1
`define UWD_CTX_ACTIVE 3'h2
`define UWD_CTX_UNPOWERED 3'h3
`define UWD_CTX_PWR_EVENT 3'h4
`define UWD_CTX_DETACHED 3'h5

// wake source bit layout: [7:0] pins, then the others
`define UWD_WS_RESUME 8
`define UWD_WS_BUSPWR 9
`define UWD_WS_MAGIC 10
`define UWD_WS_WFRAME 11
`define UWD_WS_BCAST 12
`define UWD_WS_EXACT 13
`define UWD_WS_GOOD 14
`define UWD_WS_SYN 15
`define UWD_WS_EEE_RX 16
`define UWD_WS_EEE_TX 17
`define UWD_WS_LINK 18
`define UWD_WS_W 19

`endif

// ---- hdl/uwd_regacc.v ----
`timescale 1ns/1ps
`default_nettype none
`include "uwd_defines.vh"

// one device register access at a time over a req/ack port
module uwd_regacc (
  // clock and reset
  input wire clock,
  input wire rst,
  input wire ce,
  // order from the sequencer
  input wire start,
  input wire we,
  input wire [11:0] addr,
  input wire [31:0] wdata,
  output reg done_reg,
  output reg [31:0] rdata_reg,
  // device register port
  output reg dev_req_reg,
  output reg dev_we_reg,
  output reg [11:0] dev_addr_reg,
  output reg [31:0] dev_wdata_reg,
  input wire dev_ack,
  input wire [31:0] dev_rdata
);

  // request held until ack; done is a one-cycle pulse
  always @(posedge clock) begin
    if (rst) begin
      done_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      dev_req_reg <= 1'b0;
      dev_we_reg <= 1'b0;
      dev_addr_reg <= 12'h000;
      dev_wdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      done_reg <= 1'b0;
      if (dev_req_reg) begin
        if (dev_ack) begin
          dev_req_reg <= 1'b0;
          done_reg <= 1'b1;
          if (!dev_we_reg)
            rdata_reg <= dev_rdata;
        end
      end else if (start) begin
        dev_req_reg <= 1'b1;
        dev_we_reg <= we;
        dev_addr_reg <= addr;
        dev_wdata_reg <= wdata;
      end
    end
  end

endmodule
`default_nettype wire

// ---- hdl/uwd_host.v ----
// How it works
// - arm link-up detection before detach request
// - detach only after link loss is seen
// - clear pending wakes before suspending
// - host enables remote wakeup feature; no command here enables it
// - pin enabled in a config register first
// - per-pin wake enable and polarity
// - stop mac paths before lan arming
// - exact and broadcast wake own bits
// - clear status bit 1 before lan wake
// - pick state, re-enable rx, then suspend
// - suspend select 00, 10 default, 11
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uwd_defines.vh"

module uwd_host (
  // clock and reset
  input wire clock,
  input wire rst,
  input wire ce,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // device register port
  output wire dev_req,
  output wire dev_we,
  output wire [11:0] dev_addr,
  output wire [31:0] dev_wdata,
  input wire dev_ack,
  input wire [31:0] dev_rdata,
  // status
  output reg busy_reg,
  output reg wake_illegal_reg
);

  // ----------------------------------------------------------------
  // wake matrix
  // ----------------------------------------------------------------
  // sources each power context accepts
  function [`UWD_WS_W-1:0] wake_allowed;
    input [2:0] ctx;
    reg [`UWD_WS_W-1:0] m;
    begin
      m = {`UWD_WS_W{1'b0}};
      case (ctx)
        `UWD_CTX_SLEEP_A: begin
          m = {`UWD_WS_W{1'b1}};
          m[`UWD_WS_BUSPWR] = 1'b0;
          m[`UWD_WS_GOOD] = 1'b0;
        end
        `UWD_CTX_ACTIVE: begin
          m = {`UWD_WS_W{1'b1}};
          m[`UWD_WS_BUSPWR] = 1'b0;
        end
        `UWD_CTX_DEEPEST: begin
          m[7:0] = 8'hff;
          m[`UWD_WS_RESUME] = 1'b1;
        end
        `UWD_CTX_UNPOWERED: m[`UWD_WS_BUSPWR] = 1'b1;
        `UWD_CTX_PWR_EVENT: begin
          m[7:0] = 8'hff;
          m[`UWD_WS_MAGIC] = 1'b1;
          m[`UWD_WS_WFRAME] = 1'b1;
          m[`UWD_WS_BCAST] = 1'b1;
          m[`UWD_WS_EXACT] = 1'b1;
          m[`UWD_WS_LINK] = 1'b1;
        end
        `UWD_CTX_DETACHED: begin
          m[7:0] = 8'hff;
          m[`UWD_WS_LINK] = 1'b1;
        end
        default: m = {`UWD_WS_W{1'b0}};
      endcase
      wake_allowed = m;
    end
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_ISSUE = 2'd1;
  localparam ST_WAIT = 2'd2;

  localparam OP_END = 2'd0;
  localparam OP_RD = 2'd1;
  localparam OP_WR = 2'd2;

  reg [31:0] ctrl_reg;
  reg [16:0] gpio_reg;
  reg [`UWD_WS_W-1:0] wake_src_reg;
  reg detach_ret_reg;
  reg done_reg;
  reg err_reg;
  reg [1:0] state_reg;
  reg [2:0] step_reg;
  reg [2:0] cmd_reg;
  reg [31:0] rd_reg;
  reg [1:0] op_kind;
  reg [11:0] op_addr;
  reg [31:0] op_wdata;
  wire acc_done;
  wire [31:0] acc_rdata;
  wire wb_hit;
  wire [1:0] sel_code;
  wire [2:0] ctx;
  wire [11:0] cfg_addr;
  wire lan_bad;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign sel_code = ctrl_reg[`UWD_CTRL_SEL_LSB+1:`UWD_CTRL_SEL_LSB];
  assign ctx = ctrl_reg[`UWD_CTRL_CTX_LSB+2:`UWD_CTRL_CTX_LSB];
  assign cfg_addr = gpio_reg[`UWD_GPIO_CFGB] ? `UWD_DEV_CFG_B
                                              : `UWD_DEV_CFG_A;
  // a refused lan arming must not leak its first access to the device
  assign lan_bad = cmd_reg == `UWD_CMD_LAN &&
                   sel_code != `UWD_SEL_SLEEP_A &&
                   sel_code != `UWD_SEL_ACTIVE;

  // ----------------------------------------------------------------
  // sequence table: one device access per step
  // ----------------------------------------------------------------
  // fields outside each write are left zero on purpose, except where a
  // step writes back the value it read; the device-side bits they hold
  // are re-armed by their own command
  always @* begin
    op_kind = OP_END;
    op_addr = 12'h000;
    op_wdata = 32'h0000_0000;
    case (cmd_reg)
      `UWD_CMD_DETACH:
        case (step_reg)
          3'd0: begin // link loss seen first
            op_kind = OP_RD;
            op_addr = `UWD_DEV_INTERRUPT_STATUS_REGISTER;
          end
          3'd1: begin // arm link-up wake
            op_kind = OP_WR;
            op_addr = `UWD_DEV_PMT;
            op_wdata[`UWD_PMT_PHY_WAKE] = 1'b1;
          end
          3'd2: begin
            op_kind = OP_RD;
            op_addr = `UWD_DEV_HARDWARE_CONFIG_REGISTER;
          end
          3'd3: begin // device then detaches
            op_kind = OP_WR;
            op_addr = `UWD_DEV_HARDWARE_CONFIG_REGISTER;
            op_wdata = rd_reg;
            op_wdata[`UWD_HW_DETACH_EN] = 1'b1;
          end
          default: op_kind = OP_END;
        endcase
      `UWD_CMD_GPIO:
        case (step_reg)
          3'd0: begin
            op_kind = OP_RD;
            op_addr = cfg_addr;
          end
          3'd1: begin // pin enable before wake arming
            op_kind = OP_WR;
            op_addr = cfg_addr;
            op_wdata = rd_reg;
            op_wdata[`UWD_CFG_PIN_EN_LSB+7:`UWD_CFG_PIN_EN_LSB] =
              rd_reg[`UWD_CFG_PIN_EN_LSB+7:`UWD_CFG_PIN_EN_LSB] |
              gpio_reg[7:0];
          end
          3'd2: begin // per-pin enable and level
            op_kind = OP_WR;
            op_addr = `UWD_DEV_GPIO_WAKE;
            op_wdata[15:0] = gpio_reg[15:0];
          end
          3'd3: begin // drop stale pin events
            op_kind = OP_WR;
            op_addr = `UWD_DEV_INTERRUPT_STATUS_REGISTER;
            op_wdata[7:0] = 8'hff;
          end
          3'd4: begin // state choice
            op_kind = OP_WR;
            op_addr = `UWD_DEV_PMT;
            op_wdata[`UWD_PMT_SEL_LSB+1:`UWD_PMT_SEL_LSB] = sel_code;
          end
          default: op_kind = OP_END;
        endcase
      `UWD_CMD_LAN:
        case (step_reg)
          3'd0: begin
            op_kind = OP_RD;
            op_addr = `UWD_DEV_MAC_CR;
          end
          3'd1: begin // stop both mac paths
            op_kind = OP_WR;
            op_addr = `UWD_DEV_MAC_CR;
            op_wdata = rd_reg;
            op_wdata[`UWD_MAC_RX_EN] = 1'b0;
            op_wdata[`UWD_MAC_TX_EN] = 1'b0;
          end
          3'd2: begin
            op_kind = OP_WR;
            op_addr = `UWD_DEV_WAKE_CONTROL_STATUS_1;
            op_wdata[`UWD_WU_EXACT] = ctrl_reg[`UWD_CTRL_EXACT];
            op_wdata[`UWD_WU_BCAST] = ctrl_reg[`UWD_CTRL_BCAST];
          end
          3'd3: begin // clear status bit 1
            op_kind = OP_WR;
            op_addr = `UWD_DEV_PMT;
            op_wdata[`UWD_PMT_WAKE_STATUS_BITS_LSB+1] = 1'b1;
          end
          3'd4: begin // confirm it really cleared
            op_kind = OP_RD;
            op_addr = `UWD_DEV_PMT;
          end
          3'd5: begin // enable lan wake and pick state
            op_kind = OP_WR;
            op_addr = `UWD_DEV_PMT;
            op_wdata[`UWD_PMT_LAN_WAKE] = 1'b1;
            op_wdata[`UWD_PMT_SEL_LSB+1:`UWD_PMT_SEL_LSB] = sel_code;
          end
          3'd6: begin // receive path back on
            op_kind = OP_WR;
            op_addr = `UWD_DEV_MAC_CR;
            op_wdata[`UWD_MAC_RX_EN] = 1'b1;
          end
          default: op_kind = OP_END;
        endcase
      `UWD_CMD_CHECK:
        case (step_reg)
          3'd0: begin // which event woke it
            op_kind = OP_RD;
            op_addr = `UWD_DEV_WAKE_SOURCE_REGISTER;
          end
          3'd1: begin // return from detach
            op_kind = OP_RD;
            op_addr = `UWD_DEV_HARDWARE_CONFIG_REGISTER;
          end
          3'd2: begin
            op_kind = OP_WR;
            op_addr = `UWD_DEV_WAKE_SOURCE_REGISTER;
            op_wdata[`UWD_WS_W-1:0] = wake_src_reg;
          end
          default: op_kind = OP_END;
        endcase
      `UWD_CMD_CLEAR:
        case (step_reg)
          3'd0: begin // all pending events gone
            op_kind = OP_WR;
            op_addr = `UWD_DEV_INTERRUPT_STATUS_REGISTER;
            op_wdata = 32'hffff_ffff;
          end
          3'd1: begin
            op_kind = OP_WR;
            op_addr = `UWD_DEV_WAKE_SOURCE_REGISTER;
            op_wdata = 32'hffff_ffff;
          end
          default: op_kind = OP_END;
        endcase
      default: op_kind = OP_END;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // a read is checked in the cycle its data lands, before the next
  // step can rely on a device that did not do what was asked
  always @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      step_reg <= 3'd0;
      cmd_reg <= `UWD_CMD_NONE;
      rd_reg <= 32'h0000_0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      wake_src_reg <= {`UWD_WS_W{1'b0}};
      detach_ret_reg <= 1'b0;
      wake_illegal_reg <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE:
          if (wb_hit && wb_we_i && wb_sel_i[0] &&
              wb_adr_i == `UWD_WB_CTRL && wb_dat_i[`UWD_CTRL_GO]) begin
            cmd_reg <= wb_dat_i[`UWD_CTRL_CMD_LSB+2:`UWD_CTRL_CMD_LSB];
            step_reg <= 3'd0;
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            state_reg <= ST_ISSUE;
          end
        ST_ISSUE:
          if (op_kind == OP_END) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (lan_bad) begin
            err_reg <= 1'b1; // lan wake needs state a or active
            busy_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end else
            state_reg <= ST_WAIT;
        ST_WAIT:
          if (acc_done) begin
            rd_reg <= acc_rdata;
            step_reg <= step_reg + 3'd1;
            state_reg <= ST_ISSUE;
            if (cmd_reg == `UWD_CMD_DETACH && step_reg == 3'd0 &&
                !acc_rdata[`UWD_INT_PHY]) begin
              err_reg <= 1'b1; // link not lost: no detach
              busy_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
            if (cmd_reg == `UWD_CMD_LAN && step_reg == 3'd4 &&
                acc_rdata[`UWD_PMT_WAKE_STATUS_BITS_LSB+1]) begin
              err_reg <= 1'b1; // mac event still active
              busy_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
            if (cmd_reg == `UWD_CMD_CHECK && step_reg == 3'd0) begin
              wake_src_reg <= acc_rdata[`UWD_WS_W-1:0];
              wake_illegal_reg <= |(acc_rdata[`UWD_WS_W-1:0] &
                                    ~wake_allowed(ctx));
            end
            if (cmd_reg == `UWD_CMD_CHECK && step_reg == 3'd1)
              detach_ret_reg <= acc_rdata[`UWD_HW_DETACH_RET];
          end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  uwd_regacc u_acc (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .start(state_reg == ST_ISSUE && op_kind != OP_END && !lan_bad),
    .we(op_kind == OP_WR),
    .addr(op_addr),
    .wdata(op_wdata),
    .done_reg(acc_done),
    .rdata_reg(acc_rdata),
    .dev_req_reg(dev_req),
    .dev_we_reg(dev_we),
    .dev_addr_reg(dev_addr),
    .dev_wdata_reg(dev_wdata),
    .dev_ack(dev_ack),
    .dev_rdata(dev_rdata)
  );

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  // one wait state; settings are frozen while a sequence runs so a
  // half-done arming never mixes two configurations
  always @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= `UWD_CTRL_RESET; // deepest state by default
      gpio_reg <= 17'h00000;
    end else if (ce) begin
      wb_ack_o <= wb_hit;
      if (wb_hit && wb_we_i && !busy_reg) begin
        if (wb_adr_i == `UWD_WB_CTRL) begin
          if (wb_sel_i[0])
            ctrl_reg[7:1] <= wb_dat_i[7:1];
          if (wb_sel_i[1])
            ctrl_reg[10:8] <= wb_dat_i[10:8];
        end
        if (wb_adr_i == `UWD_WB_GPIO) begin
          if (wb_sel_i[0])
            gpio_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            gpio_reg[15:8] <= wb_dat_i[15:8];
          if (wb_sel_i[2])
            gpio_reg[16] <= wb_dat_i[16];
        end
      end
      if (wb_hit && !wb_we_i)
        case (wb_adr_i)
          `UWD_WB_CTRL: wb_dat_o <= {21'h000000, ctrl_reg[10:1], 1'b0};
          `UWD_WB_GPIO: wb_dat_o <= {15'h0000, gpio_reg};
          `UWD_WB_STAT: wb_dat_o <= {22'h000000, step_reg, state_reg,
                                     detach_ret_reg, wake_illegal_reg,
                                     err_reg, done_reg, busy_reg};
          `UWD_WB_WSRC: wb_dat_o <= {13'h0000, wake_src_reg};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
    end
  end

endmodule
`default_nettype wire

// ---- testbench/uwd_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port checker for the wake controller
// ----------------------------------------------------------------
module uwd_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // device port
  input wire logic dev_req,
  input wire logic dev_we,
  input wire logic [11:0] dev_addr,
  input wire logic [31:0] dev_wdata,
  input wire logic dev_ack,
  input wire logic [31:0] dev_rdata,
  // status
  input wire logic busy_reg,
  input wire logic wake_illegal_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // a fresh request is one the slave has not answered yet
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  wire logic go = take && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];

  chk_ack_next: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == 8'h10 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_req_hold: assert property (dev_req && !dev_ack |=> dev_req &&
    $stable(dev_addr) && $stable(dev_we) && $stable(dev_wdata))
    else $error("device request changed before answer");
  chk_req_drop: assert property (dev_req && dev_ack && ce |=> !dev_req)
    else $error("device request held after answer");
  // two idle cycles keep the device from seeing merged accesses
  chk_req_gap: assert property ($fell(dev_req) |-> !dev_req ##1 !dev_req)
    else $error("device accesses too close");
  chk_go_busy: assert property (go && wb_dat_i[0] && !busy_reg &&
    wb_dat_i[3:1] inside {3'h1, 3'h2, 3'h4, 3'h5} |-> ##[1:3] busy_reg)
    else $error("command did not start");
  chk_illegal_busy: assert property (
    $changed(wake_illegal_reg) |-> $past(busy_reg))
    else $error("wake verdict changed while idle");
endmodule

bind uwd_host uwd_checker u_chk (.clock(clock), .rst(rst), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_req(dev_req),
  .dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
  .dev_ack(dev_ack), .dev_rdata(dev_rdata), .busy_reg(busy_reg),
  .wake_illegal_reg(wake_illegal_reg));
`default_nettype wire

// ---- testbench/uwd_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "uwd_defines.vh"
// ----------------------------------------------------------------
// behavioural bridge device behind the register port
// ----------------------------------------------------------------
module uwd_dev_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic dev_req,
  input wire logic dev_we,
  input wire logic [11:0] dev_addr,
  input wire logic [31:0] dev_wdata,
  output logic dev_ack,
  output logic [31:0] dev_rdata,
  // scenario knobs
  input wire logic slow,
  input wire logic mac_wake,
  input wire logic link_up
);
  localparam int INT = `UWD_DEV_INTERRUPT_STATUS_REGISTER >> 2;
  localparam int HW = `UWD_DEV_HARDWARE_CONFIG_REGISTER >> 2;
  localparam int PMT = `UWD_DEV_PMT >> 2;
  localparam int WK = `UWD_DEV_WAKE_SOURCE_REGISTER >> 2;
  logic [31:0] mem [0:127];
  logic [31:0] rd_reg;
  logic [1:0] cnt_reg;
  logic detached_reg;
  wire logic [6:0] ix = dev_addr[8:2];
  wire logic [31:0] old = mem[ix];
  // outside the answer cycle the bus shows no stale value
  assign dev_rdata = dev_ack ? rd_reg : ~rd_reg;

  initial for (int i = 0; i < 128; i++) mem[i] = 32'h0;

  // one access per request, answered at once or three cycles late
  always @(posedge clock) begin
    if (rst) begin
      dev_ack <= 1'b0;
      cnt_reg <= 2'h0;
      detached_reg <= 1'b0;
    end else begin
      dev_ack <= 1'b0;
      if (detached_reg && link_up) begin
        detached_reg <= 1'b0; // plls and both front ends, then attach
        mem[HW] <= mem[HW] | 32'h0002_0000;
        mem[WK] <= mem[WK] | 32'h0004_0000; // wake flagged
      end
      if (dev_req && !dev_ack) begin
        if (slow && cnt_reg != 2'h3) begin
          cnt_reg <= cnt_reg + 2'h1;
        end else begin
          dev_ack <= 1'b1;
          cnt_reg <= 2'h0;
          if (!dev_we) begin
            rd_reg <= old;
          end else if (ix == INT || ix == WK) begin
            mem[ix] <= old & ~dev_wdata; // sticky until cleared
          end else if (ix == HW) begin
            mem[ix] <= (dev_wdata & ~32'h0002_0000) | (old & 32'h0002_0000);
            detached_reg <= dev_wdata[16]; // leave the bus
          end else if (ix == PMT) begin
            // pending mac wake refuses to clear
            mem[ix] <= {dev_wdata[31:8], old[7] & (mac_wake | ~dev_wdata[7]),
              dev_wdata[6:0]};
          end else begin
            mem[ix] <= dev_wdata;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "uwd_defines.vh"
// ----------------------------------------------------------------
// testbench for the wake controller
// ----------------------------------------------------------------
module tb;
  localparam int INT = `UWD_DEV_INTERRUPT_STATUS_REGISTER >> 2;
  localparam int HW = `UWD_DEV_HARDWARE_CONFIG_REGISTER >> 2;
  localparam int PMT = `UWD_DEV_PMT >> 2;
  localparam int CFGB = `UWD_DEV_CFG_B >> 2;
  localparam int CFGA = `UWD_DEV_CFG_A >> 2;
  localparam int GW = `UWD_DEV_GPIO_WAKE >> 2;
  localparam int MAC = `UWD_DEV_MAC_CR >> 2;
  localparam int WU = `UWD_DEV_WAKE_CONTROL_STATUS_1 >> 2;
  localparam int WK = `UWD_DEV_WAKE_SOURCE_REGISTER >> 2;
  logic clock = 1'b0, rst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic we = 1'b0, slow = 1'b0, mac_wake = 1'b0, link_up = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0;
  wire logic [31:0] rdat, dev_wdata, dev_rdata;
  wire logic [11:0] dev_addr;
  wire logic ack, dev_req, dev_we, dev_ack, busy, illegal;
  int err_count = 0, n_checks = 0;

  always #5 clock = ~clock;

  uwd_host u_dut (.clock(clock), .rst(rst), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .dev_req(dev_req),
    .dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_ack(dev_ack), .dev_rdata(dev_rdata), .busy_reg(busy),
    .wake_illegal_reg(illegal));
  uwd_dev_model u_dev (.clock(clock), .rst(rst), .dev_req(dev_req),
    .dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_ack(dev_ack), .dev_rdata(dev_rdata), .slow(slow),
    .mac_wake(mac_wake), .link_up(link_up));

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic fail;
    err_count++;
    $display("[ERR] %0t wait ran out", $time);
    wrap_up();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle, held until the ack edge
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (ack !== 1'b1 && i < 40);
    if (i >= 40) fail();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // start a command and wait for the sequence to finish
  task automatic run(input logic [31:0] c);
    logic [31:0] q;
    int i;
    wb(1'b1, 8'h00, c | 32'h1, q);
    @(posedge clock);
    i = 0;
    while (busy !== 1'b0 && i < 400) begin
      @(posedge clock);
      i++;
    end
    if (i >= 400) fail();
  endtask

  function automatic logic [18:0] allow(input int c);
    case (c)
      0: return 19'h7bdff;
      1: return 19'h001ff;
      2: return 19'h7fdff;
      3: return 19'h00200;
      4: return 19'h43cff;
      default: return 19'h400ff;
    endcase
  endfunction

  task automatic t_reset;
    logic [31:0] q;
    wb(1'b0, 8'h00, 32'h0, q);
    check(q, 32'h20);
    wb(1'b1, 8'h10, 32'hffff_ffff, q);
    wb(1'b0, 8'h10, 32'h0, q);
    check(q, 32'h0);
  endtask

  task automatic t_detach;
    logic [31:0] q;
    slow <= 1'b1;
    u_dev.mem[INT] <= 32'h0;
    u_dev.mem[HW] <= 32'h0;
    run(32'h22);
    wb(1'b0, 8'h08, 32'h0, q);
    check(q & 32'h4, 32'h4);
    check(u_dev.mem[HW], 32'h0);
    u_dev.mem[INT] <= 32'h0400_0000;
    run(32'h22);
    check(u_dev.mem[HW], 32'h0001_0000);
    check(u_dev.mem[PMT], 32'h10);
    check({31'h0, u_dev.detached_reg}, 32'h1);
    link_up <= 1'b1;
    repeat (2) @(posedge clock);
    link_up <= 1'b0;
    check({31'h0, u_dev.detached_reg}, 32'h0);
    run(32'h528);
    check({31'h0, illegal}, 32'h0);
    wb(1'b0, 8'h08, 32'h0, q);
    check(q & 32'h14, 32'h10);
    wb(1'b0, 8'h0c, 32'h0, q);
    check(q, 32'h0004_0000);
    slow <= 1'b0;
  endtask

  task automatic t_gpio;
    logic [31:0] q;
    wb(1'b1, 8'h04, 32'h0001_a55a, q);
    u_dev.mem[CFGB] <= 32'h3;
    u_dev.mem[INT] <= 32'hf;
    run(32'h34);
    check(u_dev.mem[CFGB], 32'h5a00_0003);
    check(u_dev.mem[GW], 32'ha55a);
    check(u_dev.mem[INT], 32'h0);
    check(u_dev.mem[PMT], 32'h6000_0000);
    // second arming through config register a into sleep state a
    wb(1'b1, 8'h04, 32'h0000_0081, q);
    run(32'h04);
    check(u_dev.mem[CFGA], 32'h8100_0000);
    check(u_dev.mem[GW], 32'h81);
    check(u_dev.mem[PMT], 32'h0);
  endtask

  task automatic t_lan;
    logic [31:0] q;
    slow <= 1'b1;
    u_dev.mem[MAC] <= 32'h3;
    u_dev.mem[PMT] <= 32'h80;
    run(32'h26);
    wb(1'b0, 8'h08, 32'h0, q);
    check(q & 32'h4, 32'h4);
    check(u_dev.mem[MAC], 32'h3);
    run(32'h46);
    wb(1'b0, 8'h08, 32'h0, q);
    check(q & 32'h4, 32'h0);
    check(u_dev.mem[MAC], 32'h1);
    check(u_dev.mem[WU], 32'h200);
    check(u_dev.mem[PMT], 32'h8);
    u_dev.mem[MAC] <= 32'h3;
    u_dev.mem[PMT] <= 32'h80;
    mac_wake <= 1'b1;
    run(32'hb6);
    mac_wake <= 1'b0;
    wb(1'b0, 8'h08, 32'h0, q);
    check(q & 32'h4, 32'h4);
    check(u_dev.mem[PMT], 32'h80);
    check(u_dev.mem[WU], 32'h20);
    slow <= 1'b0;
  endtask

  task automatic t_clear;
    u_dev.mem[INT] <= 32'hffff;
    u_dev.mem[WK] <= 32'h7ffff;
    run(32'h2a);
    check(u_dev.mem[INT], 32'h0);
    check(u_dev.mem[WK], 32'h0);
  endtask

  // every context against each single wake source from bit 7 to bit 18
  task automatic t_matrix;
    logic [31:0] q;
    logic [18:0] a;
    for (int c = 0; c < 6; c++) begin
      a = allow(c);
      for (int b = 7; b < 19; b++) begin
        u_dev.mem[WK] <= 32'h1 << b;
        run(32'h28 | (32'(c) << 8));
        check({31'h0, illegal}, {31'h0, ~a[b]});
        wb(1'b0, 8'h0c, 32'h0, q);
        check(q, 32'h1 << b);
      end
    end
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_detach();
    t_gpio();
    t_lan();
    t_clear();
    t_matrix();
    wrap_up();
  end
endmodule
`default_nettype wire
